// ===== logic/bsd_pkg.sv
// Shared constants and types of the boot strap decoder.
package bsd_pkg;
   // Number of strap pins and the position of each strap in the bus.
   localparam int STRAP_W = 8;
   localparam int STRAP_EDAC_PLL = 0; // Dual use: EDAC locally, PLL remotely.
   localparam int STRAP_ROM_OFF = 1;
   localparam int STRAP_TEST_OFF = 2;
   localparam int STRAP_REDUNDANT = 3; // Also SpaceWire frequency bit 0.
   localparam int STRAP_IMAGE = 4; // Also SpaceWire frequency bit 1.
   localparam int STRAP_SRC0 = 5;
   localparam int STRAP_SRC1 = 6;
   localparam int STRAP_REMOTE = 7;

   // Cycles the synchroniser needs before the sampled straps are valid.
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;

   // SpaceWire clock figures for the PLL bypass case.
   localparam int SPW_BYPASS_MHZ = 50;
   localparam int SPW_LINK_MBIT = 10;
   localparam int SPW_DIV_W = 8;
   localparam logic [SPW_DIV_W-1:0] SPW_DIV_BYPASS =
      SPW_DIV_W'(SPW_BYPASS_MHZ / SPW_LINK_MBIT);

   // Pin IO configuration field width and codes.
   localparam int PINIO_W = 4;
   localparam logic [PINIO_W-1:0] PINIO_DEFAULT = 4'h0;
   localparam logic [PINIO_W-1:0] PINIO_SRAM = 4'h2;

   // Remote boot interface, coded as the two source straps.
   typedef enum logic [1:0] {
      BSD_RIF_SPW = 2'h0,
      BSD_RIF_SPI = 2'h1,
      BSD_RIF_I2C = 2'h2,
      BSD_RIF_UART = 2'h3
   } bsd_rif_t;

   // External memory boot source, coded as the two source straps.
   typedef enum logic [1:0] {
      BSD_SRC_SPI = 2'h0,
      BSD_SRC_SRAM = 2'h1,
      BSD_SRC_PROM = 2'h2,
      BSD_SRC_I2C = 2'h3
   } bsd_src_t;

   // Boot sequence states.
   typedef enum logic [2:0] {
      BSD_S_WAIT = 3'b000,
      BSD_S_ROM = 3'b001,
      BSD_S_CHECK = 3'b010,
      BSD_S_RUN = 3'b011,
      BSD_S_REMOTE = 3'b100,
      BSD_S_FAIL = 3'b101
   } bsd_state_t;
endpackage : bsd_pkg

// ===== logic/bsd_strap_if.sv
// Interface carrying the sampled straps from sampler to decoder.
`timescale 1ns/1ps
interface bsd_strap_if;
   import bsd_pkg::*;
   logic [STRAP_W-1:0] straps; // Straps frozen at reset release.
   logic valid; // High from the capture onward.
   modport sampler (output straps, output valid);
   modport decoder (input straps, input valid);
endinterface : bsd_strap_if

// ===== logic/bsd_strap_sampler.sv
// Synchronises the strap pins and freezes them once after reset.
`timescale 1ns/1ps
module bsd_strap_sampler (
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Strap pins from the board.
   input wire logic [bsd_pkg::STRAP_W-1:0] strap_pins,
   // Sampled straps towards the decoder.
   bsd_strap_if.sampler sif
);
   import bsd_pkg::*;

   logic [STRAP_W-1:0] sync1_reg; // First stage, read only by sync2.
   logic [STRAP_W-1:0] sync2_reg; // Second stage, safe to use.
   logic [STRAP_W-1:0] straps_reg; // Frozen copy.
   logic [1:0] settle_reg; // Counts edges until sync2 holds real pins.
   logic valid_reg; // Capture done.

   // Two-stage synchroniser; the pins are asynchronous to sys_clk.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (clk_en) begin
         sync1_reg <= strap_pins;
         sync2_reg <= sync1_reg;
      end
   end

   // Capture once after the pipeline has filled, then hold until reset.
   // A later change on the switches therefore has no effect at all.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         settle_reg <= '0;
         straps_reg <= '0;
         valid_reg <= 1'b0;
      end else if (clk_en && !valid_reg) begin
         if (settle_reg == SETTLE_CYCLES) begin
            straps_reg <= sync2_reg;
            valid_reg <= 1'b1;
         end else begin
            settle_reg <= settle_reg + 2'h1;
         end
      end
   end

   assign sif.straps = straps_reg;
   assign sif.valid = valid_reg;
endmodule : bsd_strap_sampler

// ===== logic/boot_strap_decoder.sv
// Boot strap decoder: turns reset-time straps into a boot plan.
`timescale 1ns/1ps
module boot_strap_decoder #(
   parameter int NUM_PINS = 16, // Pins with an IO configuration field.
   parameter logic [NUM_PINS-1:0] SRAM_PIN_MASK = 16'h00ff, // SRAM pins.
   parameter logic [bsd_pkg::SPW_DIV_W-1:0] SPW_DIV_PLL = 8'h01
) (
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Board strap pins, active high (switch open).
   input wire logic [bsd_pkg::STRAP_W-1:0] strap_pins,
   // Handshake with the ROM initialization sequence.
   input wire logic rom_init_done,
   output logic rom_init_run,
   output logic mem_test_en,
   // Handshake with the image CRC checker.
   input wire logic crc_done,
   input wire logic crc_ok,
   output logic crc_start,
   output logic image_from_redundant,
   // Processor control.
   output logic cpu_run,
   output logic cpu_power_down,
   output logic boot_failed,
   // Remote access.
   output logic remote_open,
   output logic remote_en,
   output bsd_pkg::bsd_rif_t remote_if,
   // Memory and clock plan.
   output bsd_pkg::bsd_src_t ext_src,
   output logic image_check_en,
   output logic redundant_en,
   output logic edac_en,
   output logic pll_en,
   output logic [1:0] spw_freq_sel,
   output logic [bsd_pkg::SPW_DIV_W-1:0] spw_clk_div,
   // Pin IO configuration, one field per pin.
   output logic [NUM_PINS*bsd_pkg::PINIO_W-1:0] pinio_cfg,
   output logic cfg_valid
);
   import bsd_pkg::*;

   bsd_strap_if sif (); // Sampled straps.

   // Strap capture lives in its own module so the pins are touched once.
   bsd_strap_sampler u_sampler (
      .sys_clk (sys_clk),
      .rst (rst),
      .clk_en (clk_en),
      .strap_pins (strap_pins),
      .sif (sif)
   );

   // Named strap wires taken from the frozen copy.
   wire logic [STRAP_W-1:0] st = sif.straps;
   wire logic st_remote = st[STRAP_REMOTE];
   wire logic st_rom_off = st[STRAP_ROM_OFF];
   wire logic st_test_off = st[STRAP_TEST_OFF];
   wire logic st_dual0 = st[STRAP_EDAC_PLL];
   wire logic st_image = st[STRAP_IMAGE];
   wire logic st_redund = st[STRAP_REDUNDANT];
   wire logic [1:0] st_src = {st[STRAP_SRC1], st[STRAP_SRC0]};

   // Decoded plan. The first strap is EDAC locally and PLL remotely.
   assign cfg_valid = sif.valid;
   assign remote_en = st_remote;
   assign remote_if = bsd_rif_t'(st_src);
   assign ext_src = bsd_src_t'(st_src);
   assign edac_en = !st_remote && st_dual0;
   assign pll_en = st_remote && st_dual0;
   // Image checking and redundancy only apply to a local boot; in remote
   // mode those two straps select the SpaceWire crystal frequency.
   assign image_check_en = !st_remote && st_image;
   assign redundant_en = image_check_en && st_redund;
   assign spw_freq_sel = st_remote ? {st_image, st_redund} : 2'h0;
   assign spw_clk_div = pll_en ? SPW_DIV_PLL : SPW_DIV_BYPASS;
   // Memory test is enabled unless the ROM sequence or the test is strapped off.
   assign mem_test_en = !st_rom_off && !st_test_off;

   // Boot sequence state.
   bsd_state_t state_reg;
   bsd_state_t state_next;
   logic red_used_reg; // Redundant copy already tried.
   logic red_used_next;
   logic crc_start_reg; // One-cycle start of an image check.
   logic crc_start_next;

   // Events that steer the sequence.
   wire logic go = clk_en && cfg_valid;
   wire logic rom_finish = state_reg == BSD_S_ROM && rom_init_done;
   wire logic chk_end = state_reg == BSD_S_CHECK && crc_done
      && !crc_start_reg;
   wire logic chk_retry = chk_end && !crc_ok && redundant_en
      && !red_used_reg;

   // Next-state logic of the boot sequence.
   always_comb begin
      state_next = state_reg;
      red_used_next = red_used_reg;
      crc_start_next = 1'b0;
      unique case (state_reg)
         BSD_S_WAIT: begin
            if (cfg_valid) begin
               if (st_rom_off) begin
                  // No ROM: straight to the source, or wait for the host.
                  state_next = st_remote ? BSD_S_REMOTE : BSD_S_RUN;
               end else begin
                  state_next = BSD_S_ROM;
               end
            end
         end
         BSD_S_ROM: begin
            if (rom_init_done) begin
               if (st_remote) begin
                  state_next = BSD_S_REMOTE;
               end else if (image_check_en) begin
                  state_next = BSD_S_CHECK;
                  crc_start_next = 1'b1;
               end else begin
                  state_next = BSD_S_RUN;
               end
            end
         end
         BSD_S_CHECK: begin
            if (chk_end) begin
               if (crc_ok) begin
                  state_next = BSD_S_RUN;
               end else if (chk_retry) begin
                  // One restart from the redundant copy, then give up.
                  red_used_next = 1'b1;
                  crc_start_next = 1'b1;
               end else begin
                  state_next = BSD_S_FAIL;
               end
            end
         end
         BSD_S_RUN: begin
            state_next = BSD_S_RUN;
         end
         BSD_S_REMOTE: begin
            state_next = BSD_S_REMOTE;
         end
         BSD_S_FAIL: begin
            state_next = BSD_S_FAIL;
         end
         default: begin
            // Illegal code: park the processor safely.
            state_next = BSD_S_FAIL;
         end
      endcase
   end

   // Boot sequence registers, frozen while the clock enable is low.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= BSD_S_WAIT;
         red_used_reg <= 1'b0;
         crc_start_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         red_used_reg <= red_used_next;
         crc_start_reg <= crc_start_next;
      end
   end

   // Sequence outputs; crc_start and image_from_redundant come from their own registers, the rest from the state register.
   assign rom_init_run = state_reg == BSD_S_ROM;
   assign crc_start = crc_start_reg;
   assign image_from_redundant = red_used_reg;
   assign cpu_run = state_reg == BSD_S_RUN;
   // The processor sleeps while the remote host owns the chip.
   assign cpu_power_down = state_reg == BSD_S_REMOTE
      || state_reg == BSD_S_FAIL;
   assign remote_open = state_reg == BSD_S_REMOTE;
   assign boot_failed = state_reg == BSD_S_FAIL;

   // Pin IO presets are loaded once, in the cycle the plan becomes valid.
   // Software may overwrite them later in its own registers; this block
   // only reports what the straps claimed.
   wire logic pin_load = go && state_reg == BSD_S_WAIT;
   wire logic sram_boot = !st_remote && ext_src == BSD_SRC_SRAM;
   logic [PINIO_W-1:0] pin_cfg_reg [NUM_PINS];

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      // One field per pin; on a local SRAM boot the SRAM pins take the SRAM function code.
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            pin_cfg_reg[i] <= PINIO_DEFAULT;
         end else if (pin_load) begin
            pin_cfg_reg[i] <= (sram_boot && SRAM_PIN_MASK[i]) ?
               PINIO_SRAM : PINIO_DEFAULT;
         end
      end
      assign pinio_cfg[i*PINIO_W +: PINIO_W] = pin_cfg_reg[i];
   end

   // Checks on the decoded plan and the boot sequence.
   property p_remote_after_init;
      @(posedge sys_clk) disable iff (rst)
      $rose(remote_open) |-> $past(rom_finish)
         || ($past(state_reg) == BSD_S_WAIT && st_rom_off);
   endproperty
   a_remote_after_init: assert property (p_remote_after_init)
      else $error("remote access opened before init ended");

   property p_remote_pd;
      @(posedge sys_clk) disable iff (rst)
      remote_open |-> cpu_power_down && !cpu_run && remote_en;
   endproperty
   a_remote_pd: assert property (p_remote_pd)
      else $error("processor not powered down under remote access");

   property p_rom_skip;
      @(posedge sys_clk) disable iff (rst)
      cfg_valid && st_rom_off |-> !rom_init_run && !mem_test_en;
   endproperty
   a_rom_skip: assert property (p_rom_skip)
      else $error("ROM sequence ran although disabled");

   property p_bypass_target;
      @(posedge sys_clk) disable iff (rst)
      state_reg == BSD_S_WAIT && cfg_valid && st_rom_off && clk_en
         |=> (st_remote ? remote_open : cpu_run);
   endproperty
   a_bypass_target: assert property (p_bypass_target)
      else $error("ROM bypass did not reach run or power-down");

   property p_test_off;
      @(posedge sys_clk) disable iff (rst)
      mem_test_en |-> !st_test_off && !st_rom_off;
   endproperty
   a_test_off: assert property (p_test_off)
      else $error("memory test enabled against strap");

   property p_check_start;
      @(posedge sys_clk) disable iff (rst)
      rom_finish && clk_en && !st_remote && image_check_en
         |=> crc_start && state_reg == BSD_S_CHECK;
   endproperty
   a_check_start: assert property (p_check_start)
      else $error("image check not started after ROM");

   property p_redundant;
      @(posedge sys_clk) disable iff (rst)
      chk_retry && clk_en |=> image_from_redundant && crc_start
         ##1 (!crc_start || !$past(clk_en));
   endproperty
   a_redundant: assert property (p_redundant)
      else $error("no restart from redundant memory");

   property p_edac_pll;
      @(posedge sys_clk) disable iff (rst)
      cfg_valid |-> !(edac_en && pll_en)
         && (edac_en || pll_en) == st_dual0;
   endproperty
   a_edac_pll: assert property (p_edac_pll)
      else $error("EDAC or PLL decode wrong");

   property p_spw_div;
      @(posedge sys_clk) disable iff (rst)
      cfg_valid && !pll_en |-> spw_clk_div == SPW_DIV_BYPASS;
   endproperty
   a_spw_div: assert property (p_spw_div)
      else $error("bypass SpaceWire divisor not five");

   property p_remote_if;
      @(posedge sys_clk) disable iff (rst)
      cfg_valid && remote_en |-> remote_if == bsd_rif_t'(st_src);
   endproperty
   a_remote_if: assert property (p_remote_if)
      else $error("remote interface decode wrong");

   property p_default_boot;
      @(posedge sys_clk) disable iff (rst)
      $rose(cfg_valid) && st == '0 && clk_en
         |=> rom_init_run && ext_src == BSD_SRC_SPI && !remote_en;
   endproperty
   a_default_boot: assert property (p_default_boot)
      else $error("default straps did not start the ROM");

   property p_pin_sram;
      @(posedge sys_clk) disable iff (rst)
      pin_load && sram_boot && SRAM_PIN_MASK[0]
         |=> pinio_cfg[PINIO_W-1:0] == PINIO_SRAM;
   endproperty
   a_pin_sram: assert property (p_pin_sram)
      else $error("SRAM pin field not preset");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      cfg_valid |=> cfg_valid && $stable(st);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sampled straps changed after capture");

   // Main scenarios.
   c_remote: cover property (@(posedge sys_clk) disable iff (rst)
      $rose(remote_open));
   c_run_checked: cover property (@(posedge sys_clk) disable iff (rst)
      $rose(cpu_run) && image_check_en);
   c_retry: cover property (@(posedge sys_clk) disable iff (rst)
      chk_retry && clk_en);
   c_fail: cover property (@(posedge sys_clk) disable iff (rst)
      $rose(boot_failed));
endmodule : boot_strap_decoder

// ===== dv/bsd_board_model.sv
// Board straps plus ROM sequence and image checker stand-ins.
`timescale 1ns/1ps
module bsd_board_model (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Scenario settings from the bench.
   input wire logic [7:0] strap_set,
   input wire logic [3:0] rom_delay,
   input wire logic [1:0] fail_n,
   // Requests from the decoder.
   input wire logic rom_init_run,
   input wire logic crc_start,
   // Answers towards the decoder.
   output logic [7:0] strap_pins,
   output logic rom_init_done,
   output logic crc_done,
   output logic crc_ok
);
   logic [3:0] rom_cnt; // Cycles spent in the ROM sequence.
   logic [2:0] wait_cnt; // Cycles left before the check answers.
   logic [1:0] tries; // Checks answered so far.

   // Switches are static levels; the bench moves them between cases.
   // They drive firm levels, so no pin is ever left to a pull mode.
   assign strap_pins = strap_set;

   // ROM sequence answers after a chosen delay, as a one-cycle pulse.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rom_cnt <= 4'h0;
         rom_init_done <= 1'b0;
      end else begin
         rom_init_done <= rom_init_run && !rom_init_done &&
            (rom_cnt == rom_delay);
         if (rom_init_run) begin
            rom_cnt <= rom_cnt + 4'h1;
         end
      end
   end

   // The image holds its codes as prepared; the first fail_n checks fail.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wait_cnt <= 3'h0;
         crc_done <= 1'b0;
         crc_ok <= 1'b0;
         tries <= 2'h0;
      end else begin
         crc_done <= 1'b0;
         // Outside its valid cycle the result toggles, so it is not trusted.
         crc_ok <= ~crc_ok;
         if (crc_start) begin
            wait_cnt <= 3'h3;
         end else if (wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
            if (wait_cnt == 3'h1) begin
               crc_done <= 1'b1;
               crc_ok <= (tries >= fail_n);
               tries <= tries + 2'h1;
            end
         end
      end
   end
endmodule : bsd_board_model

// ===== dv/boot_strap_decoder_test.sv
// Self-checking bench running each boot plan of its table through the decoder.
`timescale 1ns/1ps
module boot_strap_decoder_test;
   import bsd_pkg::*;
   localparam int NP = 16; // Pins with a configuration field.
   localparam logic [NP-1:0] MASK = 16'h00ff; // Pins used by SRAM boot.
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [7:0] strap_set = 8'h00;
   logic [3:0] rom_delay = 4'h1;
   logic [1:0] fail_n = 2'h0;
   logic [7:0] strap_pins;
   logic rom_init_done, rom_init_run, mem_test_en, crc_done, crc_ok;
   logic crc_start, image_from_redundant, cpu_run, cpu_power_down;
   logic boot_failed, remote_open, remote_en, image_check_en;
   logic redundant_en, edac_en, pll_en, cfg_valid;
   bsd_rif_t remote_if;
   bsd_src_t ext_src;
   logic [1:0] spw_freq_sel;
   logic [SPW_DIV_W-1:0] spw_clk_div;
   logic [NP*PINIO_W-1:0] pinio_cfg;
   int fails = 0;
   int n_tests = 0;
   // Straps and image check results for each case; the ROM delay is k % 4.
   logic [7:0] s_tab [16] = '{8'h00, 8'h02, 8'h04, 8'h11, 8'h18, 8'h18,
      8'h10, 8'h20, 8'h40, 8'h60, 8'h80, 8'h81, 8'h98, 8'ha0, 8'he0, 8'h82};
   logic [1:0] f_tab [16] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1,
      2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};

   // Free-running system clock, 4 ns period.
   always #2 sys_clk = ~sys_clk;

   bsd_board_model board_u (.sys_clk(sys_clk), .rst(rst),
      .strap_set(strap_set), .rom_delay(rom_delay), .fail_n(fail_n),
      .rom_init_run(rom_init_run), .crc_start(crc_start),
      .strap_pins(strap_pins), .rom_init_done(rom_init_done),
      .crc_done(crc_done), .crc_ok(crc_ok));

   boot_strap_decoder #(.NUM_PINS(NP), .SRAM_PIN_MASK(MASK)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
      .strap_pins(strap_pins), .rom_init_done(rom_init_done),
      .rom_init_run(rom_init_run), .mem_test_en(mem_test_en),
      .crc_done(crc_done), .crc_ok(crc_ok), .crc_start(crc_start),
      .image_from_redundant(image_from_redundant), .cpu_run(cpu_run),
      .cpu_power_down(cpu_power_down), .boot_failed(boot_failed),
      .remote_open(remote_open), .remote_en(remote_en),
      .remote_if(remote_if), .ext_src(ext_src),
      .image_check_en(image_check_en), .redundant_en(redundant_en),
      .edac_en(edac_en), .pll_en(pll_en), .spw_freq_sel(spw_freq_sel),
      .spw_clk_div(spw_clk_div), .pinio_cfg(pinio_cfg),
      .cfg_valid(cfg_valid));

   // Compares one value and reports a difference at once.
   task automatic check(string name, logic [63:0] seen, logic [63:0] expd);
      n_tests++;
      if (seen !== expd) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, expd, seen);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task automatic results();
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // Checks every decode against the straps taken at reset release.
   task automatic check_plan(logic [7:0] s);
      logic rmt;
      logic img;
      rmt = s[STRAP_REMOTE];
      img = !rmt && s[STRAP_IMAGE];
      check("remote_en", remote_en, rmt);
      check("remote_if", remote_if, {s[STRAP_SRC1], s[STRAP_SRC0]});
      check("ext_src", ext_src, {s[STRAP_SRC1], s[STRAP_SRC0]});
      check("mem_test_en", mem_test_en,
         !s[STRAP_ROM_OFF] && !s[STRAP_TEST_OFF]);
      check("image_check_en", image_check_en, img);
      check("redundant_en", redundant_en, img && s[STRAP_REDUNDANT]);
      check("edac_en", edac_en, !rmt && s[STRAP_EDAC_PLL]);
      check("pll_en", pll_en, rmt && s[STRAP_EDAC_PLL]);
      check("spw_freq_sel", spw_freq_sel,
         rmt ? {s[STRAP_IMAGE], s[STRAP_REDUNDANT]} : 2'h0);
      check("spw_clk_div", spw_clk_div,
         (rmt && s[STRAP_EDAC_PLL]) ? 8'h01 : 8'h05);
   endtask : check_plan

   // Resets with the given straps and follows the boot to its end.
   task automatic run_case(logic [7:0] s, logic [1:0] f, logic [3:0] d);
      logic rmt, rom_off, img, red, rom_seen, run_exp, redir;
      logic [NP*PINIO_W-1:0] pin_exp;
      int n;
      rmt = s[STRAP_REMOTE];
      rom_off = s[STRAP_ROM_OFF];
      img = !rmt && s[STRAP_IMAGE] && !rom_off;
      red = img && s[STRAP_REDUNDANT];
      run_exp = !rmt && (!img || f == 2'h0 || (f == 2'h1 && red));
      redir = red && f != 2'h0;
      for (int i = 0; i < NP; i++) begin
         pin_exp[i*PINIO_W +: PINIO_W] = (!rmt && s[6:5] == 2'h1 &&
            MASK[i]) ? PINIO_SRAM : PINIO_DEFAULT;
      end
      @(posedge sys_clk);
      strap_set <= s;
      fail_n <= f;
      rom_delay <= d;
      rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // Cases with the longest ROM delay also stall the first edge.
      clk_en <= (d != 4'h3);
      n = 0;
      do begin
         @(posedge sys_clk);
         clk_en <= 1'b1;
         #1;
         n++;
      end while (cfg_valid !== 1'b1 && n < 20);
      check("capture edge", n, SETTLE_CYCLES + 1 + (d == 4'h3));
      check("remote_open early", remote_open, 1'b0);
      check_plan(s);
      // Moving the switches after capture must change nothing.
      @(posedge sys_clk);
      strap_set <= ~s;
      rom_seen = 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
         if (rom_init_run === 1'b1) begin
            rom_seen = 1'b1;
         end
         check("open in init", remote_open & !rom_seen & !rom_off, 1'b0);
      end while (cpu_run !== 1'b1 && cpu_power_down !== 1'b1 && n < 100);
      check("rom ran", rom_seen, !rom_off);
      check("cpu_run", cpu_run, run_exp);
      check("cpu_power_down", cpu_power_down, !run_exp);
      check("remote_open", remote_open, rmt);
      check("boot_failed", boot_failed, !rmt && !run_exp);
      check("redundant restart", image_from_redundant, redir);
      check("pinio_cfg", pinio_cfg, pin_exp);
      check_plan(s);
   endtask : run_case

   // Main sequence: every boot plan of the table in turn.
   initial begin
      for (int k = 0; k < 16; k++) begin
         run_case(s_tab[k], f_tab[k], 4'(k % 4));
      end
      results();
   end

   // Watchdog well beyond the roughly 230 cycles the cases need.
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      results();
   end
endmodule : boot_strap_decoder_test
